// ### spc_params.svh
`ifndef SPC_PARAMS_SVH
`define SPC_PARAMS_SVH

// Register addresses on the serial port.
`define SPC_ADDR_CFG_A      15'h0000
`define SPC_ADDR_CFG_B      15'h0001
`define SPC_ADDR_PWR        15'h0002
`define SPC_ADDR_TYPE       15'h0003
`define SPC_ADDR_ID_LO      15'h0004
`define SPC_ADDR_CHAN_SEL   15'h0008

// Field positions in port_config_a.
`define SPC_BIT_SOFT_RST    0
`define SPC_BIT_LSB_FIRST   1
`define SPC_BIT_ADDR_ASC    2
`define SPC_BIT_ADDR_ASC_M  5
`define SPC_BIT_LSB_FIRST_M 6
`define SPC_BIT_SOFT_RST_M  7

// Field positions in port_config_b and the channel registers.
`define SPC_BIT_DP_RST      1
`define SPC_PWR_MSB         1
`define SPC_BIT_CHAN_A      0
`define SPC_BIT_CHAN_B      1

// Reset values.
`define SPC_RST_LSB_FIRST   1'b0
`define SPC_RST_ADDR_ASC    1'b0
`define SPC_RST_PWR         2'h0
`define SPC_RST_CHAN_SEL    2'h3

// Power mode codes.
`define SPC_PWR_STANDBY     2'h2
`define SPC_PWR_DOWN        2'h3

// Frame counts: the last bit index of the instruction and of a data byte.
`define SPC_INSTR_LAST      4'hf
`define SPC_BYTE_LAST       4'h7

`endif

// ### spc_pkg.sv
package spc_pkg;

  typedef enum logic [1:0] {PH_INSTR, PH_DATA, PH_HALT} spc_phase_t;

  typedef struct packed {
    spc_phase_t  phase;
    logic        sclk;
    logic [3:0]  cnt;
    logic [15:0] shreg;
    logic        rw;
    logic [14:0] addr;
    logic [7:0]  tx;
    logic        sdio;
    logic        oe;
    logic        wr_en;
    logic [14:0] wr_addr;
    logic [7:0]  wr_data;
  } spc_port_t;

  typedef struct packed {
    logic       lsb_first;
    logic       addr_asc;
    logic       port_rst;
    logic       dp_rst;
    logic [1:0] chan_sel;
    logic [1:0] pwr_a;
    logic [1:0] pwr_b;
  } spc_bank_t;

endpackage

// ### spc_reg_bank.sv
`timescale 1ns/10ps
`default_nettype none
`include "spc_params.svh"

module spc_reg_bank
  import spc_pkg::*;
#(
  parameter logic [7:0] TYPE_CODE = 8'h5a, // Arbitrary value.
  parameter logic [7:0] PART_CODE = 8'h21  // Arbitrary value.
) (
  input  wire logic        clk_in,           // System clock
  input  wire logic        rst_n_in,         // Synchronous reset, active low
  input  wire logic        wr_en_in,         // Write strobe
  input  wire logic [14:0] addr_in,          // Register address
  input  wire logic [7:0]  wr_data_in,       // Write data
  output logic      [7:0]  rd_data_out,      // Read data at addr_in
  output logic             lsb_first_out,    // Bit order select
  output logic             addr_asc_out,     // Address stepping direction
  output logic             port_rst_out,     // Port reset pulse
  output logic             datapath_rst_out, // Datapath reset pulse
  output logic      [1:0]  pwr_mode_a_out,   // Channel A power mode
  output logic      [1:0]  pwr_mode_b_out    // Channel B power mode
);

  localparam spc_bank_t RST_VAL = '{
    lsb_first: `SPC_RST_LSB_FIRST, addr_asc: `SPC_RST_ADDR_ASC,
    port_rst: 1'b0, dp_rst: 1'b0, chan_sel: `SPC_RST_CHAN_SEL,
    pwr_a: `SPC_RST_PWR, pwr_b: `SPC_RST_PWR};

  spc_bank_t q, d;

  always_comb
  begin
    d          = q;
    d.port_rst = 1'b0;
    d.dp_rst   = 1'b0;
    if (wr_en_in)
    begin
      unique case (addr_in)
        `SPC_ADDR_CFG_A:
          // [R1] [R3] soft reset
          if (wr_data_in[`SPC_BIT_SOFT_RST] || wr_data_in[`SPC_BIT_SOFT_RST_M])
          begin
            d          = RST_VAL;
            d.port_rst = 1'b1;
          end
          else
          begin
            // [R4] [R5] bit order
            d.lsb_first = wr_data_in[`SPC_BIT_LSB_FIRST] | wr_data_in[`SPC_BIT_LSB_FIRST_M];
            // [R6] [R7] address stepping
            d.addr_asc  = wr_data_in[`SPC_BIT_ADDR_ASC] | wr_data_in[`SPC_BIT_ADDR_ASC_M];
          end
        // [R8] datapath reset
        `SPC_ADDR_CFG_B: d.dp_rst = wr_data_in[`SPC_BIT_DP_RST];
        `SPC_ADDR_PWR:
        begin
          // [R13] per-channel write
          if (q.chan_sel[`SPC_BIT_CHAN_A])
            d.pwr_a = wr_data_in[`SPC_PWR_MSB:0];
          if (q.chan_sel[`SPC_BIT_CHAN_B])
            d.pwr_b = wr_data_in[`SPC_PWR_MSB:0];
        end
        `SPC_ADDR_CHAN_SEL: d.chan_sel = wr_data_in[`SPC_BIT_CHAN_B:0];
        // [R15] read-only and open addresses ignore writes
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      q <= RST_VAL;
    else
      q <= d;
  end

  // [R15] reserved bits read zero
  always_comb
  begin
    rd_data_out = 8'h00;
    unique case (addr_in)
      `SPC_ADDR_CFG_A:    rd_data_out = {1'b0, q.lsb_first, q.addr_asc, 2'h0,
                                         q.addr_asc, q.lsb_first, 1'b0};
      `SPC_ADDR_PWR:      rd_data_out = {6'h00, q.chan_sel[`SPC_BIT_CHAN_A] ? q.pwr_a : q.pwr_b};
      `SPC_ADDR_TYPE:     rd_data_out = TYPE_CODE;
      `SPC_ADDR_ID_LO:    rd_data_out = PART_CODE;
      `SPC_ADDR_CHAN_SEL: rd_data_out = {6'h00, q.chan_sel};
      default:            rd_data_out = 8'h00;
    endcase
  end

  assign lsb_first_out    = q.lsb_first;
  assign addr_asc_out     = q.addr_asc;
  assign port_rst_out     = q.port_rst;
  assign datapath_rst_out = q.dp_rst;
  assign pwr_mode_a_out   = q.pwr_a;
  assign pwr_mode_b_out   = q.pwr_b;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  wire soft_wr = wr_en_in && addr_in == `SPC_ADDR_CFG_A &&
                 (wr_data_in[`SPC_BIT_SOFT_RST] || wr_data_in[`SPC_BIT_SOFT_RST_M]);

  sequence s_defaults;
    port_rst_out && !lsb_first_out && !addr_asc_out && pwr_mode_a_out == 2'h0 &&
    pwr_mode_b_out == 2'h0;
  endsequence

  property p_soft_rst;
    soft_wr |=> s_defaults ##1 !port_rst_out;
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("soft reset did not restore defaults"); // [R1]

  property p_lsb_mirror;
    (wr_en_in && addr_in == `SPC_ADDR_CFG_A && !soft_wr) |=>
      lsb_first_out == ($past(wr_data_in[1]) | $past(wr_data_in[6])) && rd_data_out[1] == rd_data_out[6];
  endproperty
  a_lsb_mirror: assert property (p_lsb_mirror) else $error("bit order mirror wrong"); // [R5]

  property p_asc_mirror;
    (wr_en_in && addr_in == `SPC_ADDR_CFG_A && !soft_wr) |=>
      addr_asc_out == ($past(wr_data_in[2]) | $past(wr_data_in[5]));
  endproperty
  a_asc_mirror: assert property (p_asc_mirror) else $error("stepping mirror wrong"); // [R7]

  property p_dp_rst;
    (wr_en_in && addr_in == `SPC_ADDR_CFG_B && wr_data_in[1]) |=> datapath_rst_out ##1 !datapath_rst_out;
  endproperty
  a_dp_rst: assert property (p_dp_rst) else $error("datapath reset not one pulse"); // [R8]

  property p_both_chan;
    (wr_en_in && addr_in == `SPC_ADDR_PWR && q.chan_sel == 2'h3) |=>
      pwr_mode_a_out == $past(wr_data_in[1:0]) && pwr_mode_b_out == $past(wr_data_in[1:0]);
  endproperty
  a_both_chan: assert property (p_both_chan) else $error("both channels not updated"); // [R13]

  property p_reserved;
    (addr_in == `SPC_ADDR_PWR || addr_in == `SPC_ADDR_CFG_B) |-> rd_data_out[7:2] == 6'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero"); // [R15]

  property p_ro_type;
    addr_in == `SPC_ADDR_TYPE |-> rd_data_out == TYPE_CODE;
  endproperty
  a_ro_type: assert property (p_ro_type) else $error("type code changed"); // [R15]

endmodule // spc_reg_bank

`default_nettype wire

// ### spc_serial_port_regs.sv
// Behaviour
// [R1] Writing 1 to config A bit 0 resets port and registers, then clears.
// [R2] Host waits 5 ms after soft reset before writing other registers; the bench host waits RECOVER, 200 clock cycles.
// [R3] Config A bit 7 mirrors the soft reset bit with the same effect.
// [R4] Config A bit 1 selects LSB first when 1, MSB first when 0.
// [R5] Config A bit 6 mirrors the bit order control.
// [R6] Config A bit 2 makes multibyte addresses count up when 1, down when 0.
// [R7] Config A bit 5 mirrors the address stepping control.
// [R8] Config B bit 1 pulses a datapath-only reset and clears itself.
// [R9] Channel power mode field resets to normal operation, code 00.
// [R10] Mode 10 gates datapath clocks while the output link stays enabled.
// [R11] Mode 11 gates clocks, holds datapath reset and disables the link.
// [R12] Host never writes addresses outside the register map.
// [R13] Per-channel writes update every channel selected in the index register.
// [R14] Host issues soft reset by writing 0x81 to config A; the bench also writes 0x80 and 0x01.
// [R15] Reserved bits read zero; type and identity registers ignore writes.
`timescale 1ns/10ps
`default_nettype none
`include "spc_params.svh"

module spc_serial_port_regs
  import spc_pkg::*;
(
  input  wire logic       clk_in,            // 200 MHz system clock
  input  wire logic       rst_n_in,          // Synchronous reset, active low
  input  wire logic       sclk_in,           // Serial clock from the host
  input  wire logic       csb_n_in,          // Frame select, active low
  input  wire logic       sdio_in,           // Serial data from the host
  output logic            sdio_out,          // Serial read data
  output logic            sdio_oe_out,       // High while driving sdio
  output logic            datapath_rst_out,  // Datapath reset pulse
  output logic      [1:0] dp_clk_gate_out,   // Datapath clocks gated, per channel
  output logic      [1:0] dp_hold_rst_out,   // Datapath held in reset, per channel
  output logic      [1:0] link_en_out        // Serial output link enabled, per channel
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic logic [15:0] spc_shift(input logic [15:0] w, input logic b,
                                            input logic lsb);
    spc_shift = lsb ? {b, w[15:1]} : {w[14:0], b};
  endfunction

  function automatic logic [7:0] spc_byte(input logic [15:0] w, input logic lsb);
    spc_byte = lsb ? w[15:8] : w[7:0];
  endfunction

  function automatic logic [14:0] spc_step(input logic [14:0] a, input logic up);
    spc_step = up ? 15'(a + 15'h0001) : 15'(a - 15'h0001);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Register bank.

  logic       lsb_first;
  logic       addr_asc;
  logic       port_rst;
  logic [7:0] rd_data;
  logic [1:0] pwr_a;
  logic [1:0] pwr_b;

  spc_port_t q, d;

  spc_reg_bank u_bank (
    .clk_in           (clk_in),
    .rst_n_in         (rst_n_in),
    .wr_en_in         (q.wr_en),
    .addr_in          (q.wr_en ? q.wr_addr : q.addr),
    .wr_data_in       (q.wr_data),
    .rd_data_out      (rd_data),
    .lsb_first_out    (lsb_first),
    .addr_asc_out     (addr_asc),
    .port_rst_out     (port_rst),
    .datapath_rst_out (datapath_rst_out),
    .pwr_mode_a_out   (pwr_a),
    .pwr_mode_b_out   (pwr_b)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Serial frame engine. The serial clock is sampled; both of its edges
  // are found by comparing against the last sample, so sclk must stay
  // well below a quarter of the system clock.

  wire rise = !csb_n_in && sclk_in && !q.sclk;
  wire fall = !csb_n_in && !sclk_in && q.sclk;

  logic [7:0] out_byte;

  always_comb
  begin
    d        = q;
    d.sclk   = sclk_in;
    d.wr_en  = 1'b0;
    out_byte = (q.cnt == 4'h0) ? rd_data : q.tx;
    if (csb_n_in)
    begin
      d.phase = PH_INSTR;
      d.cnt   = 4'h0;
      d.oe    = 1'b0;
    end
    else if (port_rst)
    begin
      // [R1] port logic halts until the frame ends
      d.phase = PH_HALT;
      d.oe    = 1'b0;
    end
    else if (rise)
    begin
      unique case (q.phase)
        PH_INSTR:
        begin
          // [R4] bit order of instruction
          d.shreg = spc_shift(q.shreg, sdio_in, lsb_first);
          d.cnt   = 4'(q.cnt + 4'h1);
          if (q.cnt == `SPC_INSTR_LAST)
          begin
            d.rw    = d.shreg[15];
            d.addr  = d.shreg[14:0];
            d.phase = PH_DATA;
            d.cnt   = 4'h0;
          end
        end
        PH_DATA:
        begin
          d.shreg = spc_shift(q.shreg, sdio_in, lsb_first);
          d.cnt   = 4'(q.cnt + 4'h1);
          if (q.cnt == `SPC_BYTE_LAST)
          begin
            d.wr_en   = !q.rw;
            d.wr_addr = q.addr;
            d.wr_data = spc_byte(d.shreg, lsb_first);
            // [R6] address stepping
            d.addr    = spc_step(q.addr, addr_asc);
            d.cnt     = 4'h0;
          end
        end
        PH_HALT: ;
      endcase
    end
    else if (fall && q.phase == PH_DATA && q.rw)
    begin
      // [R4] bit order of readback
      d.tx   = out_byte;
      d.sdio = lsb_first ? out_byte[q.cnt[2:0]] : out_byte[3'h7 - q.cnt[2:0]];
      d.oe   = 1'b1;
    end
  end

  localparam spc_port_t PORT_RST = '{phase: PH_INSTR, default: '0};

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      q <= PORT_RST;
    else
      q <= d;
  end

  assign sdio_out    = q.sdio;
  assign sdio_oe_out = q.oe;

  ////////////////////////////////////////////////////////////////////////////////
  // Channel power decode. Code 01 is not defined and is treated as normal.

  // [R9] [R10] [R11] power mode decode
  assign dp_clk_gate_out = {pwr_b[`SPC_PWR_MSB], pwr_a[`SPC_PWR_MSB]};
  assign dp_hold_rst_out = {pwr_b == `SPC_PWR_DOWN, pwr_a == `SPC_PWR_DOWN};
  assign link_en_out     = {pwr_b != `SPC_PWR_DOWN, pwr_a != `SPC_PWR_DOWN};

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_first_bit;
    (fall && q.phase == PH_DATA && q.rw && q.cnt == 4'h0 && !port_rst) |=>
      sdio_oe_out && sdio_out == ($past(lsb_first) ? $past(rd_data[0]) : $past(rd_data[7]));
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("first read bit in wrong order"); // [R4]

  property p_addr_step;
    (rise && q.phase == PH_DATA && q.cnt == `SPC_BYTE_LAST && !port_rst) |=>
      q.addr == ($past(addr_asc) ? 15'($past(q.addr) + 15'h0001) : 15'($past(q.addr) - 15'h0001));
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("address stepped wrong way"); // [R6]

  sequence s_quiet;
    !sdio_oe_out [*2];
  endsequence

  property p_port_halt;
    port_rst |=> s_quiet;
  endproperty
  a_port_halt: assert property (p_port_halt) else $error("port kept driving after reset"); // [R1]

  property p_standby;
    (pwr_a == `SPC_PWR_STANDBY) |-> dp_clk_gate_out[0] && link_en_out[0] && !dp_hold_rst_out[0];
  endproperty
  a_standby: assert property (p_standby) else $error("standby decode wrong"); // [R10]

  property p_power_down;
    (pwr_b == `SPC_PWR_DOWN) |-> dp_clk_gate_out[1] && dp_hold_rst_out[1] && !link_en_out[1];
  endproperty
  a_power_down: assert property (p_power_down) else $error("power-down decode wrong"); // [R11]

  property p_normal;
    (pwr_a == `SPC_RST_PWR && pwr_b == `SPC_RST_PWR) |->
      dp_clk_gate_out == 2'h0 && dp_hold_rst_out == 2'h0 && link_en_out == 2'h3;
  endproperty
  a_normal: assert property (p_normal) else $error("normal mode decode wrong"); // [R9]

  property p_standby_b;
    (pwr_b == `SPC_PWR_STANDBY) |-> dp_clk_gate_out[1] && link_en_out[1] && !dp_hold_rst_out[1];
  endproperty
  a_standby_b: assert property (p_standby_b) else $error("standby decode wrong"); // [R10]

  property p_power_down_a;
    (pwr_a == `SPC_PWR_DOWN) |-> dp_clk_gate_out[0] && dp_hold_rst_out[0] && !link_en_out[0];
  endproperty
  a_power_down_a: assert property (p_power_down_a) else $error("down decode wrong"); // [R11]

  // Readback must let go of the shared data wire once the frame ends, or it
  // fights the next instruction from the host.
  property p_rd_release;
    csb_n_in |=> !sdio_oe_out;
  endproperty
  a_rd_release: assert property (p_rd_release) else $error("data wire held after frame"); // [R4]

endmodule // spc_serial_port_regs

`default_nettype wire

// ### spc_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module spc_host_model #(
  parameter int HALF    = 4,  // Clock cycles per serial clock level
  parameter int RECOVER = 200 // Gap after soft reset, shortened to keep runs short
) (
  input  wire logic clk_in,    // Bench clock
  input  wire logic sdio_in,   // Resolved serial data wire
  output logic      sclk_out,  // Serial clock to the device
  output logic      csb_n_out, // Frame select, active low
  output logic      sdio_out   // Host drive of the data wire
);
  logic lsb_first;

  initial
    begin
      sclk_out  = 1'b0;
      csb_n_out = 1'b1;
      sdio_out  = 1'b0;
      lsb_first = 1'b0;
    end

  //////////////////////////////////////////////////////////////////////////
  // When not driving, the host toggles its line so stale data never looks valid.
  task automatic shift_bit(input logic b, input logic drive, output logic got);
    @(negedge clk_in);
    sclk_out = 1'b0;
    sdio_out = drive ? b : ~sdio_out;
    repeat (HALF) @(negedge clk_in);
    got = sdio_in;
    sclk_out = 1'b1;
    repeat (HALF - 1) @(negedge clk_in);
  endtask

  task automatic frame(input logic rd, input logic [14:0] addr, input int n,
                       input logic [31:0] wdata, output logic [31:0] rdata);
    logic [15:0] ins;
    logic        got;
    int          k;
    ins = {rd, addr};
    rdata = '0;
    @(negedge clk_in);
    csb_n_out = 1'b0;
    for (int i = 0; i < 16; i++)
      begin
        k = lsb_first ? i : 15 - i;
        shift_bit(ins[k], 1'b1, got);
      end
    for (int j = 0; j < n; j++)
      for (int i = 0; i < 8; i++)
        begin
          k = lsb_first ? i : 7 - i;
          shift_bit(wdata[8*j+k], !rd, got);
          rdata[8*j+k] = got;
        end
    @(negedge clk_in);
    sclk_out = 1'b0;
    repeat (HALF) @(negedge clk_in);
    csb_n_out = 1'b1;
    sdio_out = ~sdio_out;
    repeat (2 * HALF) @(negedge clk_in);
  endtask

  task automatic wait_recover();
    repeat (RECOVER) @(negedge clk_in);
  endtask
endmodule // spc_host_model

`default_nettype wire

// ### spc_serial_port_regs_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "spc_params.svh"

`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin miscompares++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end

module spc_serial_port_regs_test;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        sclk_in;
  logic        csb_n_in;
  logic        host_sdio;
  logic        sdio_out;
  logic        sdio_oe_out;
  logic        datapath_rst_out;
  logic [1:0]  dp_clk_gate_out;
  logic [1:0]  dp_hold_rst_out;
  logic [1:0]  link_en_out;
  wire         sdio_wire = sdio_oe_out ? sdio_out : host_sdio;
  int          miscompares = 0;
  int          n_tests = 0;
  int          cycles = 0;
  int          dp_pulses = 0;
  logic [31:0] rd_q;
  logic [14:0] ra [7] = '{15'h0000, 15'h0001, 15'h0002, 15'h0003, 15'h0004, 15'h0008, 15'h0007};
  logic [7:0]  rv [7] = '{8'h00, 8'h00, 8'h00, 8'h5a, 8'h21, 8'h03, 8'h00};
  logic [7:0]  sr [3] = '{8'h81, 8'h80, 8'h01};

  always #2.5 clk_in = ~clk_in;

  spc_serial_port_regs uut (
    .clk_in           (clk_in),
    .rst_n_in         (rst_n_in),
    .sclk_in          (sclk_in),
    .csb_n_in         (csb_n_in),
    .sdio_in          (sdio_wire),
    .sdio_out         (sdio_out),
    .sdio_oe_out      (sdio_oe_out),
    .datapath_rst_out (datapath_rst_out),
    .dp_clk_gate_out  (dp_clk_gate_out),
    .dp_hold_rst_out  (dp_hold_rst_out),
    .link_en_out      (link_en_out)
  );

  spc_host_model host (
    .clk_in    (clk_in),
    .sdio_in   (sdio_wire),
    .sclk_out  (sclk_in),
    .csb_n_out (csb_n_in),
    .sdio_out  (host_sdio)
  );

  //////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [31:0] x;
    host.frame(1'b0, a, 1, {24'h0, d}, x);
  endtask

  task automatic rd(input logic [14:0] a, input int n, output logic [31:0] q);
    host.frame(1'b1, a, n, 32'h0, q);
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Sampled at the falling edge, away from the edge that launches the pulse.
  always @(negedge clk_in)
    begin
      cycles++;
      if (datapath_rst_out === 1'b1)
        dp_pulses++;
      // The whole sequence needs about 11k cycles; this leaves ample margin.
      if (cycles == 80000)
        begin
          miscompares++;
          close_out();
        end
    end

  //////////////////////////////////////////////////////////////////////////
  initial
    begin
      repeat (12) @(negedge clk_in);
      rst_n_in = 1'b1;
      `CHK("link_en", 2'h3, link_en_out)
      `CHK("clk_gate", 2'h0, dp_clk_gate_out)
      `CHK("hold_rst", 2'h0, dp_hold_rst_out)
      // Address 0x0007 is only read, never written.
      foreach (ra[i])
        begin
          rd(ra[i], 1, rd_q);
          `CHK("reset_value", rv[i], rd_q[7:0])
        end
      `CHK("oe_idle", 1'h0, sdio_oe_out)
      wr(`SPC_ADDR_TYPE, 8'hff);
      rd(`SPC_ADDR_TYPE, 1, rd_q);
      `CHK("type_code", 8'h5a, rd_q[7:0])
      wr(`SPC_ADDR_CFG_A, 8'h1c);
      rd(`SPC_ADDR_CFG_A, 1, rd_q);
      `CHK("cfg_a", 8'h24, rd_q[7:0])
      rd(`SPC_ADDR_PWR, 2, rd_q);
      `CHK("stream_up", 16'h5a00, rd_q[15:0])
      wr(`SPC_ADDR_CFG_A, 8'h00);
      rd(`SPC_ADDR_ID_LO, 2, rd_q);
      `CHK("stream_down", 16'h5a21, rd_q[15:0])
      wr(`SPC_ADDR_CFG_A, 8'h20);
      rd(`SPC_ADDR_TYPE, 2, rd_q);
      `CHK("stream_mirror", 16'h215a, rd_q[15:0])
      wr(`SPC_ADDR_CFG_A, 8'h02);
      host.lsb_first = 1'b1;
      rd(`SPC_ADDR_CFG_A, 1, rd_q);
      `CHK("cfg_a_lsb", 8'h42, rd_q[7:0])
      wr(`SPC_ADDR_CFG_A, 8'h40);
      rd(`SPC_ADDR_CFG_A, 1, rd_q);
      `CHK("cfg_a_lsb_mirror", 8'h42, rd_q[7:0])
      wr(`SPC_ADDR_CFG_A, 8'h00);
      host.lsb_first = 1'b0;
      rd(`SPC_ADDR_CFG_A, 1, rd_q);
      `CHK("cfg_a_msb", 8'h00, rd_q[7:0])
      wr(`SPC_ADDR_CHAN_SEL, 8'h01);
      wr(`SPC_ADDR_PWR, 8'h02);
      `CHK("clk_gate", 2'h1, dp_clk_gate_out)
      `CHK("link_en", 2'h3, link_en_out)
      `CHK("hold_rst", 2'h0, dp_hold_rst_out)
      wr(`SPC_ADDR_CHAN_SEL, 8'h02);
      wr(`SPC_ADDR_PWR, 8'h03);
      `CHK("clk_gate", 2'h3, dp_clk_gate_out)
      `CHK("hold_rst", 2'h2, dp_hold_rst_out)
      `CHK("link_en", 2'h1, link_en_out)
      rd(`SPC_ADDR_PWR, 1, rd_q);
      `CHK("pwr_b", 8'h03, rd_q[7:0])
      wr(`SPC_ADDR_CHAN_SEL, 8'h03);
      wr(`SPC_ADDR_PWR, 8'h00);
      `CHK("hold_rst", 2'h0, dp_hold_rst_out)
      `CHK("clk_gate", 2'h0, dp_clk_gate_out)
      dp_pulses = 0;
      wr(`SPC_ADDR_CFG_B, 8'h02);
      `CHK("dp_pulses", 32'h1, dp_pulses)
      rd(`SPC_ADDR_CFG_B, 1, rd_q);
      `CHK("cfg_b", 8'h00, rd_q[7:0])
      foreach (sr[i])
        begin
          wr(`SPC_ADDR_CFG_A, 8'h04);
          wr(`SPC_ADDR_CHAN_SEL, 8'h01);
          wr(`SPC_ADDR_PWR, 8'h03);
          `CHK("link_en", 2'h2, link_en_out)
          wr(`SPC_ADDR_CFG_A, sr[i]);
          host.wait_recover();
          `CHK("link_en", 2'h3, link_en_out)
          rd(`SPC_ADDR_CFG_A, 1, rd_q);
          `CHK("cfg_a_after_reset", 8'h00, rd_q[7:0])
          rd(`SPC_ADDR_CHAN_SEL, 1, rd_q);
          `CHK("chan_sel_after_reset", 8'h03, rd_q[7:0])
        end
      close_out();
    end
endmodule // spc_serial_port_regs_test

`default_nettype wire
